/* File: sdc_pkg.sv */
package sdc_pkg;

  // ==========================================================
  // register offsets (byte-wide registers, one per word)
  // ==========================================================
  localparam logic [7:0] OFF_REF_M_DIVIDER = 8'h35;
  localparam logic [7:0] OFF_CONTROL_MAIN = 8'h38;
  localparam logic [7:0] OFF_CONTROL_PUMP = 8'h39;
  localparam logic [7:0] OFF_INT_DIV_HIGH = 8'h3a;
  localparam logic [7:0] OFF_INT_DIV_LOW = 8'h3b;
  localparam logic [7:0] OFF_NUMER_TOP = 8'h3c;
  localparam logic [7:0] OFF_NUMER_MID = 8'h3d;
  localparam logic [7:0] OFF_NUMER_LOW = 8'h3e;
  localparam logic [7:0] OFF_DENOM_TOP = 8'h3f;
  localparam logic [7:0] OFF_DENOM_MID = 8'h40;
  localparam logic [7:0] OFF_DENOM_LOW = 8'h41;
  localparam logic [7:0] OFF_MODULATOR = 8'h42;
  localparam logic [7:0] OFF_FILTER_R2 = 8'h43;
  localparam logic [7:0] OFF_FILTER_C1 = 8'h44;
  localparam logic [7:0] OFF_FILTER_R3 = 8'h45;
  localparam logic [7:0] OFF_FILTER_C3 = 8'h46;
  localparam logic [7:0] OFF_SEC_REF = 8'h48;
  localparam logic [7:0] OFF_STATUS = 8'h49;

  // ==========================================================
  // writable-bit masks per register
  // ==========================================================
  localparam logic [7:0] MASK_M_DIV = 8'h1f;
  localparam logic [7:0] MASK_MAIN = 8'h1f;
  localparam logic [7:0] MASK_PUMP = 8'h3f;
  localparam logic [7:0] MASK_NIB = 8'h0f;
  localparam logic [7:0] MASK_BYTE = 8'hff;
  localparam logic [7:0] MASK_SIX = 8'h3f;
  localparam logic [7:0] MASK_THREE = 8'h07;
  localparam logic [7:0] MASK_R3 = 8'h7f;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [7:0] RST_M_DIV = 8'h00;
  localparam logic [7:0] RST_MAIN = 8'h1e;
  localparam logic [7:0] RST_PUMP = 8'h18;
  localparam logic [7:0] RST_INT_HIGH = 8'h00;
  localparam logic [7:0] RST_INT_LOW = 8'h66;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MODULATOR = 8'h0c;
  localparam logic [7:0] RST_R2 = 8'h24;
  localparam logic [7:0] RST_SEC_REF = 8'h18;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int POS_POST_LO = 2;
  localparam int POS_SYNC_EN = 1;
  localparam int POS_PDN = 0;
  localparam int POS_DOUBLER = 4;
  localparam int POS_DITHER_LO = 2;
  localparam int POS_R3_LO = 1;
  localparam int POS_FRAC_MODE = 0;

  // ==========================================================
  // calibration timing
  // ==========================================================
  localparam int CAL_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [7:0] CAL_CYCLES = 8'(CAL_TIME_NS / CLK_PERIOD_NS);

  // pump current in units of 0.1 mA
  localparam logic [7:0] PUMP_STEP_TENTHS = 8'h04;
  localparam logic [7:0] PUMP_MAX_TENTHS = 8'h40;

  typedef enum logic [2:0] {
    SDC_CAL_OFF = 3'b001,
    SDC_CAL_RUN = 3'b010,
    SDC_CAL_LOCK = 3'b100
  } sdc_cal_state_t;

  typedef struct packed {
    logic [5:0] m_ratio;
    logic [3:0] post_ratio;
    logic [11:0] n_ratio;
    logic [21:0] numerator;
    logic [21:0] denominator;
    logic [1:0] dither;
    logic [1:0] order;
    logic [7:0] pump_tenths;
    logic primary_doubler;
    logic secondary_doubler;
    logic [5:0] r2_code;
    logic [5:0] r3_code;
    logic [2:0] c1_code;
    logic [2:0] c3_code;
    logic fractional_filter;
  } sdc_synth_cfg_t;

endpackage

/* File: sdc_synth_divider_config.sv */
`timescale 1ns/1ns
`default_nettype none
module sdc_synth_divider_config (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic realign_event_i,
  output logic realign_o,
  output logic synth_enable_o,
  output logic cal_reset_o,
  output logic cal_active_o,
  output sdc_pkg::sdc_synth_cfg_t cfg_o
);

  // ==========================================================
  // register storage
  // ==========================================================
  logic [7:0] m_div_r;
  logic [7:0] main_r;
  logic [7:0] pump_r;
  logic [7:0] int_high_r;
  logic [7:0] int_low_r;
  logic [7:0] numer_top_r;
  logic [7:0] numer_mid_r;
  logic [7:0] numer_low_r;
  logic [7:0] denom_top_r;
  logic [7:0] denom_mid_r;
  logic [7:0] denom_low_r;
  logic [7:0] modulator_r;
  logic [7:0] r2_r;
  logic [7:0] c1_r;
  logic [7:0] r3_r;
  logic [7:0] c3_r;
  logic [7:0] sec_ref_r;
  logic realign_sync1_r;
  logic realign_meta_r;
  logic realign_sync_r;
  sdc_pkg::sdc_cal_state_t cal_state_r;
  sdc_pkg::sdc_cal_state_t cal_state_nxt;
  logic [7:0] cal_count_r;

  // bus decode and the power-down level used by the sequencer
  logic [7:0] byte_adr;
  logic wr_stb;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic pdn;

  // only byte lane 0 carries data; word address picks the register
  assign byte_adr = wb_adr_i[9:2];
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];
  assign pdn = main_r[sdc_pkg::POS_PDN];

  // masked write keeps reserved bits at zero
  function automatic logic [7:0] wmask(input logic [7:0] data, input logic [7:0] mask);
    wmask = data & mask;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // ==========================================================
  // register writes, one block per concern
  // ==========================================================
  // reference divider, main control and pump control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_div_r <= sdc_pkg::RST_M_DIV;
      main_r <= sdc_pkg::RST_MAIN;
      pump_r <= sdc_pkg::RST_PUMP;
    end else if (wr_stb) begin
      if (hit(byte_adr, sdc_pkg::OFF_REF_M_DIVIDER)) begin
        m_div_r <= wmask(wr_byte, sdc_pkg::MASK_M_DIV);
      end
      if (hit(byte_adr, sdc_pkg::OFF_CONTROL_MAIN)) begin
        main_r <= wmask(wr_byte, sdc_pkg::MASK_MAIN);
      end
      if (hit(byte_adr, sdc_pkg::OFF_CONTROL_PUMP)) begin
        pump_r <= wmask(wr_byte, sdc_pkg::MASK_PUMP);
      end
    end
  end

  // integer and fractional divider words; each byte lands on its own,
  // so the ratio is briefly mixed between the byte writes of one update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_high_r <= sdc_pkg::RST_INT_HIGH;
      int_low_r <= sdc_pkg::RST_INT_LOW;
      numer_top_r <= sdc_pkg::RST_ZERO;
      numer_mid_r <= sdc_pkg::RST_ZERO;
      numer_low_r <= sdc_pkg::RST_ZERO;
      denom_top_r <= sdc_pkg::RST_ZERO;
      denom_mid_r <= sdc_pkg::RST_ZERO;
      denom_low_r <= sdc_pkg::RST_ZERO;
    end else if (wr_stb) begin
      if (hit(byte_adr, sdc_pkg::OFF_INT_DIV_HIGH)) begin
        int_high_r <= wmask(wr_byte, sdc_pkg::MASK_NIB);
      end
      if (hit(byte_adr, sdc_pkg::OFF_INT_DIV_LOW)) begin
        int_low_r <= wmask(wr_byte, sdc_pkg::MASK_BYTE);
      end
      if (hit(byte_adr, sdc_pkg::OFF_NUMER_TOP)) begin
        numer_top_r <= wmask(wr_byte, sdc_pkg::MASK_SIX);
      end
      if (hit(byte_adr, sdc_pkg::OFF_NUMER_MID)) begin
        numer_mid_r <= wr_byte;
      end
      if (hit(byte_adr, sdc_pkg::OFF_NUMER_LOW)) begin
        numer_low_r <= wr_byte;
      end
      if (hit(byte_adr, sdc_pkg::OFF_DENOM_TOP)) begin
        denom_top_r <= wmask(wr_byte, sdc_pkg::MASK_SIX);
      end
      if (hit(byte_adr, sdc_pkg::OFF_DENOM_MID)) begin
        denom_mid_r <= wr_byte;
      end
      if (hit(byte_adr, sdc_pkg::OFF_DENOM_LOW)) begin
        denom_low_r <= wr_byte;
      end
    end
  end

  // modulator, loop-filter codes and secondary reference control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      modulator_r <= sdc_pkg::RST_MODULATOR;
      r2_r <= sdc_pkg::RST_R2;
      c1_r <= sdc_pkg::RST_ZERO;
      r3_r <= sdc_pkg::RST_ZERO;
      c3_r <= sdc_pkg::RST_ZERO;
      sec_ref_r <= sdc_pkg::RST_SEC_REF;
    end else if (wr_stb) begin
      if (hit(byte_adr, sdc_pkg::OFF_MODULATOR)) begin
        modulator_r <= wmask(wr_byte, sdc_pkg::MASK_NIB);
      end
      if (hit(byte_adr, sdc_pkg::OFF_FILTER_R2)) begin
        r2_r <= wmask(wr_byte, sdc_pkg::MASK_SIX);
      end
      if (hit(byte_adr, sdc_pkg::OFF_FILTER_C1)) begin
        c1_r <= wmask(wr_byte, sdc_pkg::MASK_THREE);
      end
      if (hit(byte_adr, sdc_pkg::OFF_FILTER_R3)) begin
        r3_r <= wmask(wr_byte, sdc_pkg::MASK_R3);
      end
      if (hit(byte_adr, sdc_pkg::OFF_FILTER_C3)) begin
        c3_r <= wmask(wr_byte, sdc_pkg::MASK_THREE);
      end
      if (hit(byte_adr, sdc_pkg::OFF_SEC_REF)) begin
        sec_ref_r <= wmask(wr_byte, sdc_pkg::MASK_PUMP);
      end
    end
  end

  // ==========================================================
  // read mux; unmapped offsets read zero and still ack
  // ==========================================================
  always_comb begin
    case (byte_adr)
      sdc_pkg::OFF_REF_M_DIVIDER: rd_byte = m_div_r;
      sdc_pkg::OFF_CONTROL_MAIN: rd_byte = main_r;
      sdc_pkg::OFF_CONTROL_PUMP: rd_byte = pump_r;
      sdc_pkg::OFF_INT_DIV_HIGH: rd_byte = int_high_r;
      sdc_pkg::OFF_INT_DIV_LOW: rd_byte = int_low_r;
      sdc_pkg::OFF_NUMER_TOP: rd_byte = numer_top_r;
      sdc_pkg::OFF_NUMER_MID: rd_byte = numer_mid_r;
      sdc_pkg::OFF_NUMER_LOW: rd_byte = numer_low_r;
      sdc_pkg::OFF_DENOM_TOP: rd_byte = denom_top_r;
      sdc_pkg::OFF_DENOM_MID: rd_byte = denom_mid_r;
      sdc_pkg::OFF_DENOM_LOW: rd_byte = denom_low_r;
      sdc_pkg::OFF_MODULATOR: rd_byte = modulator_r;
      sdc_pkg::OFF_FILTER_R2: rd_byte = r2_r;
      sdc_pkg::OFF_FILTER_C1: rd_byte = c1_r;
      sdc_pkg::OFF_FILTER_R3: rd_byte = r3_r;
      sdc_pkg::OFF_FILTER_C3: rd_byte = c3_r;
      sdc_pkg::OFF_SEC_REF: rd_byte = sec_ref_r;
      sdc_pkg::OFF_STATUS: rd_byte = {5'h0_0, cal_state_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // one-cycle registered ack; dropped the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // calibration sequencer
  // ==========================================================
  // a drop of power-down sends the machine back to run, so clearing
  // the bit always restarts a full calibration
  always_comb begin
    case (cal_state_r)
      sdc_pkg::SDC_CAL_OFF: cal_state_nxt = pdn ? sdc_pkg::SDC_CAL_OFF : sdc_pkg::SDC_CAL_RUN;
      sdc_pkg::SDC_CAL_RUN: begin
        if (pdn) begin
          cal_state_nxt = sdc_pkg::SDC_CAL_OFF;
        end else if (cal_count_r == sdc_pkg::CAL_CYCLES) begin
          cal_state_nxt = sdc_pkg::SDC_CAL_LOCK;
        end else begin
          cal_state_nxt = sdc_pkg::SDC_CAL_RUN;
        end
      end
      sdc_pkg::SDC_CAL_LOCK: cal_state_nxt = pdn ? sdc_pkg::SDC_CAL_OFF : sdc_pkg::SDC_CAL_LOCK;
      default: cal_state_nxt = sdc_pkg::SDC_CAL_OFF;
    endcase
  end

  // reset lands in run: auto-calibration after hardware reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_state_r <= sdc_pkg::SDC_CAL_RUN;
    end else begin
      cal_state_r <= cal_state_nxt;
    end
  end

  // counts run cycles; cleared elsewhere so every restart starts from zero
  always_ff @(posedge clk_i) begin
    if (rst_i || cal_state_r != sdc_pkg::SDC_CAL_RUN) begin
      cal_count_r <= 8'h00;
    end else begin
      cal_count_r <= cal_count_r + 8'h01;
    end
  end

  // calibration outputs follow the next state so they line up with the state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      synth_enable_o <= 1'b0;
      cal_reset_o <= 1'b1;
      cal_active_o <= 1'b0;
    end else begin
      synth_enable_o <= ~pdn;
      cal_reset_o <= pdn | (cal_state_nxt == sdc_pkg::SDC_CAL_OFF);
      cal_active_o <= (cal_state_nxt == sdc_pkg::SDC_CAL_RUN);
    end
  end

  // ==========================================================
  // realignment: event pin is asynchronous, synchronise first
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      realign_meta_r <= 1'b0;
      realign_sync_r <= 1'b0;
      realign_sync1_r <= 1'b0;
      realign_o <= 1'b0;
    end else begin
      realign_meta_r <= realign_event_i;
      realign_sync_r <= realign_meta_r;
      realign_sync1_r <= realign_sync_r;
      // rising edge of the event, gated by the enable
      realign_o <= realign_sync_r & ~realign_sync1_r & main_r[sdc_pkg::POS_SYNC_EN];
    end
  end

  // ==========================================================
  // ratio decoding
  // ==========================================================
  // m code 0 is the bypass, which is a ratio of 1
  function automatic logic [5:0] m_ratio_of(input logic [4:0] code);
    m_ratio_of = 6'(code) + 6'h01;
  endfunction

  // the post-divider has no divide by 1, so code 1 aliases code 0
  function automatic logic [3:0] post_ratio_of(input logic [2:0] code);
    if (code < 3'h2) begin
      post_ratio_of = 4'h2;
    end else begin
      post_ratio_of = 4'(code) + 4'h1;
    end
  endfunction

  // codes 0 and 1 both give a ratio of 1
  function automatic logic [11:0] n_ratio_of(input logic [11:0] code);
    if (code < 12'h002) begin
      n_ratio_of = 12'h001;
    end else begin
      n_ratio_of = code;
    end
  endfunction

  // tenths of a milliamp; codes 0 and 9..15 give no current
  function automatic logic [7:0] pump_tenths_of(input logic [3:0] code);
    if (code == 4'h8) begin
      pump_tenths_of = sdc_pkg::PUMP_MAX_TENTHS;
    end else if (code < 4'h8) begin
      // widened first: a 4-bit product would wrap from code 4 up
      pump_tenths_of = 8'(code) * sdc_pkg::PUMP_STEP_TENTHS;
    end else begin
      pump_tenths_of = 8'h00;
    end
  endfunction

  // numerator and denominator share one byte arrangement
  function automatic logic [21:0] frac_word(input logic [7:0] top, input logic [7:0] mid,
    input logic [7:0] low);
    frac_word = {top[5:0], mid, low};
  endfunction

  // ==========================================================
  // decoded configuration
  // ==========================================================
  logic [11:0] n_code;
  logic [2:0] p_code;
  logic [3:0] cp_code;
  assign n_code = {int_high_r[3:0], int_low_r};
  assign p_code = main_r[sdc_pkg::POS_POST_LO +: 3];
  assign cp_code = pump_r[3:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else begin
      // ratio 1 means bypass
      cfg_o.m_ratio <= m_ratio_of(m_div_r[4:0]);
      cfg_o.post_ratio <= post_ratio_of(p_code);
      cfg_o.n_ratio <= n_ratio_of(n_code);
      // fraction words change as each byte lands
      cfg_o.numerator <= frac_word(numer_top_r, numer_mid_r, numer_low_r);
      cfg_o.denominator <= frac_word(denom_top_r, denom_mid_r, denom_low_r);
      cfg_o.dither <= modulator_r[sdc_pkg::POS_DITHER_LO +: 2];
      cfg_o.order <= modulator_r[1:0];
      cfg_o.pump_tenths <= pump_tenths_of(cp_code);
      // doublers and loop-filter codes pass through as stored
      cfg_o.primary_doubler <= pump_r[sdc_pkg::POS_DOUBLER];
      cfg_o.secondary_doubler <= sec_ref_r[sdc_pkg::POS_DOUBLER];
      cfg_o.r2_code <= r2_r[5:0];
      cfg_o.r3_code <= r3_r[sdc_pkg::POS_R3_LO +: 6];
      cfg_o.c1_code <= c1_r[2:0];
      cfg_o.c3_code <= c3_r[2:0];
      // software keeps this in step with the order field
      cfg_o.fractional_filter <= r3_r[sdc_pkg::POS_FRAC_MODE];
    end
  end

endmodule
`default_nettype wire

/* File: sdc_config_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module sdc_config_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic realign_event_i,
  input wire logic realign_o,
  input wire logic synth_enable_o,
  input wire logic cal_reset_o,
  input wire logic cal_active_o,
  input wire sdc_pkg::sdc_synth_cfg_t cfg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // control write steps
  // ==========================================================
  // request still held while ack is seen, so data is valid here
  sequence main_wr_s;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == 8'h38;
  endsequence
  sequence pdn_set_s;
    main_wr_s ##0 wb_dat_i[0];
  endsequence
  sequence pdn_clr_s;
    main_wr_s ##0 (!wb_dat_i[0] && !synth_enable_o);
  endsequence
  // ==========================================================
  // bus and control relations
  // ==========================================================
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_pad_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000
    && (wb_adr_i[9:2] != 8'h47 || wb_dat_o[7:0] == 8'h00)) else $error("read bits not zero");
  pdn_disable_a: assert property (pdn_set_s |-> ##[1:2]
    (!synth_enable_o && cal_reset_o && !cal_active_o)) else $error("power-down ignored");
  cal_restart_a: assert property (pdn_clr_s |-> ##[1:3] cal_active_o)
    else $error("calibration did not restart");
  cal_exclusive_a: assert property (!(cal_active_o && cal_reset_o))
    else $error("calibration runs while held");
  realign_pulse_a: assert property (realign_o |=> !realign_o)
    else $error("realign pulse too long");
  realign_cause_a: assert property (realign_o |-> $past(realign_event_i, 2)
    || $past(realign_event_i, 3) || $past(realign_event_i, 4)) else $error("stray realign");
  // first edge after reset still shows cleared outputs, hence the guard
  ratio_range_a: assert property (!$past(rst_i) |-> cfg_o.m_ratio inside {[6'h01:6'h20]}
    && cfg_o.post_ratio inside {[4'h2:4'h8]} && cfg_o.n_ratio != 12'h000)
    else $error("ratio out of range");
endmodule
bind sdc_synth_divider_config sdc_config_asserts sdc_config_asserts_inst (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .realign_event_i, .realign_o, .synth_enable_o, .cal_reset_o,
  .cal_active_o, .cfg_o
);
`default_nettype wire

/* File: sdc_synth_divider_config_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module sdc_synth_divider_config_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, realign_event_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, q, r;
  logic wb_ack_o, realign_o, synth_enable_o, cal_reset_o, cal_active_o;
  sdc_pkg::sdc_synth_cfg_t cfg_o;
  int n_mismatch = 0, checked = 0, k, c;
  logic [31:0] seed = 32'h0000_0d54;
  logic [7:0] mdl [0:255];
  logic [15:0] t;
  logic [7:0] ix;

  always #5 clk_i = ~clk_i;

  sdc_synth_divider_config sdc_synth_divider_config_inst (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .realign_event_i, .realign_o, .synth_enable_o, .cal_reset_o, .cal_active_o, .cfg_o);

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // {writable mask, reset value}; unmapped places are all zero
  function automatic logic [15:0] info(input logic [7:0] i);
    case (i)
      8'h35: return 16'h1f00;
      8'h38: return 16'h1f1e;
      8'h39, 8'h48: return 16'h3f18;
      8'h3a: return 16'h0f00;
      8'h3b: return 16'hff66;
      8'h3c, 8'h3f: return 16'h3f00;
      8'h3d, 8'h3e, 8'h40, 8'h41: return 16'hff00;
      8'h42: return 16'h0f0c;
      8'h43: return 16'h3f24;
      8'h44, 8'h46: return 16'h0700;
      8'h45: return 16'h7f00;
      default: return 16'h0000;
    endcase
  endfunction
  // decoded settings worked out from the register image
  function automatic sdc_pkg::sdc_synth_cfg_t exp_cfg();
    sdc_pkg::sdc_synth_cfg_t e;
    logic [11:0] n;
    logic [2:0] p;
    logic [3:0] cp;
    n = {mdl[8'h3a][3:0], mdl[8'h3b]};
    p = mdl[8'h38][4:2];
    cp = mdl[8'h39][3:0];
    e.m_ratio = {1'b0, mdl[8'h35][4:0]} + 6'h01;
    e.post_ratio = (p < 3'h2) ? 4'h2 : {1'b0, p} + 4'h1;
    e.n_ratio = (n < 12'h002) ? 12'h001 : n;
    e.numerator = {mdl[8'h3c][5:0], mdl[8'h3d], mdl[8'h3e]};
    e.denominator = {mdl[8'h3f][5:0], mdl[8'h40], mdl[8'h41]};
    e.dither = mdl[8'h42][3:2];
    e.order = mdl[8'h42][1:0];
    e.pump_tenths = (cp == 4'h8) ? 8'h40 : (cp < 4'h8) ? {4'h0, cp} * 8'h04 : 8'h00;
    e.primary_doubler = mdl[8'h39][4];
    e.secondary_doubler = mdl[8'h48][4];
    e.r2_code = mdl[8'h43][5:0];
    e.r3_code = mdl[8'h45][6:1];
    e.c1_code = mdl[8'h44][2:0];
    e.c3_code = mdl[8'h46][2:0];
    e.fractional_filter = mdl[8'h45][0];
    return e;
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one classic cycle; the model follows only an acked, enabled write
  task automatic wb(input logic we, input logic [7:0] i, input logic [7:0] d, input logic s);
    int n;
    logic [15:0] m;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= {3'h7, s};
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    q = wb_dat_o;
    m = info(i);
    if (we && s) mdl[i] = (mdl[i] & ~m[15:8]) | (d & m[15:8]);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i);
    wb(1'b0, i, 8'h00, 1'b1);
    check(q, {24'h00_0000, mdl[i]});
  endtask
  // event held four cycles; count pulses seen in the window
  task automatic realign(input int expn);
    c = 0;
    @(posedge clk_i);
    realign_event_i <= 1'b1;
    for (int j = 0; j < 12; j++) begin
      @(posedge clk_i);
      if (j == 3) realign_event_i <= 1'b0;
      if (realign_o === 1'b1) c++;
    end
    check(c, expn);
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    for (k = 0; k < 256; k++) begin
      t = info(k[7:0]);
      mdl[k] = t[7:0];
    end
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check({synth_enable_o, cal_active_o, cal_reset_o}, 3'b110);
    check(cfg_o, exp_cfg());
    for (k = 8'h35; k <= 8'h48; k++) rd(k[7:0]);
    c = 0;
    while (cal_active_o === 1'b1 && c < 300) begin
      @(posedge clk_i);
      c++;
    end
    check({cal_active_o, cal_reset_o, synth_enable_o}, 3'b001);
    // status word shows calibration done
    wb(1'b0, 8'h49, 8'h00, 1'b1);
    check(q, 32'h0000_0004);
    realign(1);
    wb(1'b1, 8'h38, 8'h1c, 1'b1);
    realign(0);
    wb(1'b1, 8'h38, 8'h1f, 1'b1);
    repeat (2) @(posedge clk_i);
    #1;
    check({synth_enable_o, cal_reset_o, cal_active_o}, 3'b010);
    wb(1'b0, 8'h49, 8'h00, 1'b1);
    check(q, 32'h0000_0001);
    wb(1'b1, 8'h38, 8'h1e, 1'b1);
    c = 0;
    while (cal_active_o !== 1'b1 && c < 8) @(posedge clk_i) c++;
    c = 0;
    while (cal_active_o === 1'b1 && c < 300) @(posedge clk_i) c++;
    check(c >= 100 && c <= 104, 1'b1);
    // corner codes: every pump, post, dither and order code, n of 0, 1, 0xfff
    for (k = 0; k < 16; k++) begin
      wb(1'b1, 8'h39, {3'h0, k[0], k[3:0]}, 1'b1);
      wb(1'b1, 8'h38, {3'h0, k[2:0], 2'b10}, 1'b1);
      wb(1'b1, 8'h42, {4'h0, k[3:0]}, 1'b1);
      wb(1'b1, 8'h45, {1'b0, k[3:0], 2'h0, k[1:0] != 2'h0}, 1'b1);
      wb(1'b1, 8'h35, k[0] ? 8'h1f : 8'h00, 1'b1);
      wb(1'b1, 8'h3a, k > 1 ? 8'hff : 8'h00, 1'b1);
      wb(1'b1, 8'h3b, k > 1 ? 8'hff : k[7:0], 1'b1);
      @(posedge clk_i);
      #1;
      check(cfg_o, exp_cfg());
    end
    // random writes, some with the byte lane off, each read back
    repeat (60) begin
      r = rnd();
      ix = (r[4:0] > 5'd16) ? 8'h35 : 8'h38 + {3'h0, r[4:0]};
      wb(1'b1, ix, r[15:8], r[17:16] != 2'b00);
      rd(ix);
      #1;
      check(cfg_o, exp_cfg());
    end
    conclude();
  end

  // hang guard
  initial begin
    repeat (50000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
